// [verilog/hes_exposure_seq.sv]
// HDR exposure sequencer: registers, exposure timing, knee points, row sets
`timescale 1ns/1ps
`default_nettype none
module hes_exposure_seq (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [hes_pkg::ADDR_W-1:0] regAddr,
   input wire logic [hes_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   output logic [hes_pkg::DATA_W-1:0] regRdData,
   input wire logic frameReq,
   input wire logic firstExposureTrigger,
   input wire logic secondExposureTrigger,
   input wire logic [hes_pkg::ROW_W-1:0] rowIndex,
   output logic evenExposing,
   output logic oddExposing,
   output logic rowExposing,
   output logic exposureDone,
   output logic [1:0] clipStage,
   output logic clipEnable,
   output logic [hes_pkg::CLIP_W-1:0] clipLevel
);
   // Configuration registers
   logic colorSel_q;
   logic extSel_q;
   logic interleave_q;
   logic [hes_pkg::TIME_W-1:0] expPri_q;
   logic [hes_pkg::TIME_W-1:0] expSec_q;
   logic [hes_pkg::TIME_W-1:0] knee1_q;
   logic [hes_pkg::TIME_W-1:0] knee2_q;
   logic [1:0] slopes_q;
   logic [7:0] fot_q;
   logic [6:0] clip2_q;
   logic [6:0] clip3_q;

   // Byte offset within a three-byte value, lowest address least significant
   function automatic logic [1:0] byteSel(input logic [6:0] a, input logic [6:0] base);
      logic [6:0] diff;
      diff = a - base;
      byteSel = (a >= base && diff < 7'h03) ? diff[1:0] : 2'h3;
   endfunction : byteSel

   function automatic logic [23:0] putByte(input logic [23:0] old, input logic [1:0] sel,
                                           input logic [7:0] d);
      logic [23:0] r;
      r = old;
      if (sel == 2'h0)
         r[7:0] = d;
      else if (sel == 2'h1)
         r[15:8] = d;
      else if (sel == 2'h2)
         r[23:16] = d;
      putByte = r;
   endfunction : putByte

   function automatic logic [7:0] getByte(input logic [23:0] v, input logic [1:0] sel);
      getByte = (sel == 2'h0) ? v[7:0] : (sel == 2'h1) ? v[15:8] :
                (sel == 2'h2) ? v[23:16] : 8'h00;
   endfunction : getByte

   wire [1:0] selPri = byteSel(regAddr, hes_pkg::ADDR_EXP_PRI);
   wire [1:0] selSec = byteSel(regAddr, hes_pkg::ADDR_EXP_SEC);
   wire [1:0] selK1 = byteSel(regAddr, hes_pkg::ADDR_KNEE1);
   wire [1:0] selK2 = byteSel(regAddr, hes_pkg::ADDR_KNEE2);
   wire hitColor = (regAddr == hes_pkg::ADDR_COLOR_SEL);
   wire hitCtrl = (regAddr == hes_pkg::ADDR_EXP_CTRL);
   wire hitSlopes = (regAddr == hes_pkg::ADDR_SLOPES);
   wire hitFot = (regAddr == hes_pkg::ADDR_FOT);
   wire hitClip2 = (regAddr == hes_pkg::ADDR_CLIP2);
   wire hitClip3 = (regAddr == hes_pkg::ADDR_CLIP3);

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         colorSel_q <= hes_pkg::RST_COLOR_SEL[0];
         extSel_q <= hes_pkg::RST_EXP_CTRL[hes_pkg::BIT_EXT_SEL];
         interleave_q <= hes_pkg::RST_EXP_CTRL[hes_pkg::BIT_INTERLEAVE];
         expPri_q <= hes_pkg::RST_EXP_TIME;
         expSec_q <= hes_pkg::RST_EXP_TIME;
         knee1_q <= hes_pkg::RST_KNEE;
         knee2_q <= hes_pkg::RST_KNEE;
         slopes_q <= hes_pkg::RST_SLOPES;
         fot_q <= hes_pkg::RST_FOT;
         clip2_q <= hes_pkg::RST_CLIP;
         clip3_q <= hes_pkg::RST_CLIP;
      end
      else if (regWrEn)
      begin
         if (hitColor)
            colorSel_q <= regWrData[0];
         if (hitCtrl)
         begin
            extSel_q <= regWrData[hes_pkg::BIT_EXT_SEL];
            interleave_q <= regWrData[hes_pkg::BIT_INTERLEAVE];
         end
         expPri_q <= putByte(expPri_q, selPri, regWrData);
         expSec_q <= putByte(expSec_q, selSec, regWrData);
         knee1_q <= putByte(knee1_q, selK1, regWrData);
         knee2_q <= putByte(knee2_q, selK2, regWrData);
         if (hitSlopes)
            slopes_q <= regWrData[1:0];
         if (hitFot)
            fot_q <= regWrData;
         if (hitClip2)
            clip2_q <= regWrData[6:0];
         if (hitClip3)
            clip3_q <= regWrData[6:0];
      end
   end

   wire [7:0] rdPri = getByte(expPri_q, selPri);
   wire [7:0] rdSec = getByte(expSec_q, selSec);
   wire [7:0] rdK1 = getByte(knee1_q, selK1);
   wire [7:0] rdK2 = getByte(knee2_q, selK2);
   wire [7:0] rdMisc = hitColor ? {7'h00, colorSel_q} :
                       hitCtrl ? {6'h00, interleave_q, extSel_q} :
                       hitSlopes ? {6'h00, slopes_q} :
                       hitFot ? fot_q :
                       hitClip2 ? {1'b0, clip2_q} :
                       hitClip3 ? {1'b0, clip3_q} : 8'h00;
   // Unmapped addresses read as zero
   wire [7:0] rdNext = rdPri | rdSec | rdK1 | rdK2 | rdMisc;

   // Read data come from a register, one cycle after the address
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         regRdData <= '0;
      else
         regRdData <= rdNext;
   end

   // Overhead term 0.43 x length, truncated to whole units
   localparam logic [14:0] OVH_NUM_EXT = {8'h00, hes_pkg::OVH_NUM};
   wire [14:0] fotProd = fot_q * OVH_NUM_EXT;
   wire [14:0] fotQuot = fotProd / hes_pkg::OVH_DEN;
   wire [hes_pkg::TGT_W-1:0] ovhTerm = {10'h000, fotQuot};

   // Slope field outside 1..3 behaves as a single slope
   wire [1:0] slopesEff = (slopes_q == 2'h0) ? 2'h1 : slopes_q;

   hes_pkg::hes_state_t state_q;
   hes_pkg::hes_state_t state_d;

   logic trig1Prev_q;
   logic trig2Prev_q;
   wire trig1Rise = firstExposureTrigger && !trig1Prev_q;
   wire trig2Rise = secondExposureTrigger && !trig2Prev_q;

   wire [hes_pkg::TGT_W-1:0] target [hes_pkg::N_TIMERS];
   wire [hes_pkg::N_TIMERS-1:0] tStart;
   wire [hes_pkg::N_TIMERS-1:0] tBusy;
   wire [hes_pkg::N_TIMERS-1:0] tDone;
   wire tick;
   wire tickOvh;

   assign target[hes_pkg::T_EVEN] = {1'b0, expPri_q} + ovhTerm;
   assign target[hes_pkg::T_ODD] = {1'b0, expSec_q} + ovhTerm;
   assign target[hes_pkg::T_KNEE1] = {1'b0, knee1_q} + ovhTerm;
   assign target[hes_pkg::T_KNEE2] = {1'b0, knee2_q} + ovhTerm;
   assign target[hes_pkg::T_OVH] = ovhTerm;

   wire idleState = (state_q == hes_pkg::ST_IDLE);
   wire startInt = idleState && !extSel_q && frameReq;
   wire startExt = idleState && extSel_q && trig1Rise;
   wire startSession = startInt || startExt;

   assign tStart[hes_pkg::T_EVEN] = startInt;
   assign tStart[hes_pkg::T_ODD] = startInt && interleave_q;
   assign tStart[hes_pkg::T_KNEE1] = startSession;
   assign tStart[hes_pkg::T_KNEE2] = startSession;
   assign tStart[hes_pkg::T_OVH] = (state_q == hes_pkg::ST_EXT_EXP) && frameReq;

   // Session divider, restarted together with the knee timers and, in internal mode, the row timers
   hes_tick_gen u_tick (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .restart(startSession),
      .tick(tick)
   );

   // Overhead timer starts on frame request mid-session, so it needs its own unit phase
   hes_tick_gen u_tick_ovh (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .restart(tStart[hes_pkg::T_OVH]),
      .tick(tickOvh)
   );

   genvar gi;
   generate
      for (gi = 0; gi < hes_pkg::N_TIMERS; gi++)
      begin : g_timer
         hes_unit_timer u_timer (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .start(tStart[gi]),
            .tick((gi == hes_pkg::T_OVH) ? tickOvh : tick),
            .target(target[gi]),
            .busy(tBusy[gi]),
            .donePulse(tDone[gi])
         );
      end
   endgenerate

   // Internal session ends when the enabled row timers are all idle
   wire intBusy = tBusy[hes_pkg::T_EVEN] || (interleave_q && tBusy[hes_pkg::T_ODD]);
   wire intEnd = (state_q == hes_pkg::ST_INT_EXP) && !intBusy;
   wire extEnd = (state_q == hes_pkg::ST_EXT_OVH) && tDone[hes_pkg::T_OVH];

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         hes_pkg::ST_IDLE:
         begin
            if (startInt)
               state_d = hes_pkg::ST_INT_EXP;
            else if (startExt)
               state_d = hes_pkg::ST_EXT_EXP;
         end
         hes_pkg::ST_INT_EXP:
         begin
            if (intEnd)
               state_d = hes_pkg::ST_IDLE;
         end
         hes_pkg::ST_EXT_EXP:
         begin
            if (frameReq)
               state_d = hes_pkg::ST_EXT_OVH;
         end
         hes_pkg::ST_EXT_OVH:
         begin
            if (extEnd)
               state_d = hes_pkg::ST_IDLE;
         end
      endcase
   end

   // Exposure levels per row set
   logic extEven_q;
   logic extOdd_q;
   wire extActive = (state_q == hes_pkg::ST_EXT_EXP) || (state_q == hes_pkg::ST_EXT_OVH);
   wire intActive = (state_q == hes_pkg::ST_INT_EXP);
   // Rows stop in the cycle the session ends, so done never overlaps exposing
   wire extLive = extActive && !extEnd;
   wire evenNow = intActive ? tBusy[hes_pkg::T_EVEN] : (extLive && extEven_q);
   wire oddNow = intActive ? (interleave_q ? tBusy[hes_pkg::T_ODD] : tBusy[hes_pkg::T_EVEN])
                           : (extLive && extOdd_q);
   // Colour sensor alternates single rows; with the colour bit clear each row pair shares one exposure
   wire rowOdd = colorSel_q ? rowIndex[0] : rowIndex[1];
   wire rowNow = rowOdd ? oddNow : evenNow;

   // Piecewise-linear clip stage advances in order, so at most two changes
   logic [1:0] stage_q;
   logic [1:0] stage_d;
   wire sessionLive = intActive || extActive;
   wire toStage1 = sessionLive && (stage_q == 2'h0) && tDone[hes_pkg::T_KNEE1] &&
                   (slopesEff >= 2'h2);
   wire toStage2 = sessionLive && (stage_q == 2'h1) && tDone[hes_pkg::T_KNEE2] &&
                   (slopesEff == 2'h3);
   assign stage_d = startSession ? 2'h0 :
                    toStage1 ? 2'h1 :
                    toStage2 ? 2'h2 : stage_q;
   wire [6:0] clipSel = (stage_d == 2'h2) ? clip3_q : clip2_q;
   wire clipEnNow = (stage_d != 2'h0) && clipSel[hes_pkg::BIT_CLIP_EN];

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_q <= hes_pkg::ST_IDLE;
         trig1Prev_q <= 1'b0;
         trig2Prev_q <= 1'b0;
         extEven_q <= 1'b0;
         extOdd_q <= 1'b0;
         stage_q <= 2'h0;
      end
      else
      begin
         state_q <= state_d;
         trig1Prev_q <= firstExposureTrigger;
         trig2Prev_q <= secondExposureTrigger;
         stage_q <= stage_d;
         if (startExt)
         begin
            extEven_q <= 1'b1;
            extOdd_q <= !interleave_q;
         end
         else if (extEnd)
         begin
            extEven_q <= 1'b0;
            extOdd_q <= 1'b0;
         end
         else if (extActive && interleave_q && trig2Rise)
            extOdd_q <= 1'b1;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         evenExposing <= 1'b0;
         oddExposing <= 1'b0;
         rowExposing <= 1'b0;
         exposureDone <= 1'b0;
         clipStage <= 2'h0;
         clipEnable <= 1'b0;
         clipLevel <= '0;
      end
      else
      begin
         evenExposing <= evenNow;
         oddExposing <= oddNow;
         rowExposing <= rowNow;
         exposureDone <= intEnd || extEnd;
         clipStage <= stage_d;
         clipEnable <= clipEnNow && sessionLive;
         clipLevel <= clipSel[hes_pkg::CLIP_W-1:0];
      end
   end
endmodule : hes_exposure_seq
`default_nettype wire

// [verilog/hes_pkg.sv]
// Constants and types shared by the exposure sequencer files
package hes_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int TIME_W = 24;
   localparam int TGT_W = 25;
   localparam int ROW_W = 11;

   localparam logic [6:0] ADDR_COLOR_SEL = 7'h27;
   localparam logic [6:0] ADDR_EXP_CTRL = 7'h29;
   localparam logic [6:0] ADDR_EXP_PRI = 7'h2a;
   localparam logic [6:0] ADDR_KNEE1 = 7'h30;
   localparam logic [6:0] ADDR_KNEE2 = 7'h33;
   localparam logic [6:0] ADDR_SLOPES = 7'h36;
   localparam logic [6:0] ADDR_EXP_SEC = 7'h38;
   localparam logic [6:0] ADDR_FOT = 7'h49;
   localparam logic [6:0] ADDR_CLIP2 = 7'h59;
   localparam logic [6:0] ADDR_CLIP3 = 7'h5a;

   localparam int BIT_EXT_SEL = 0;
   localparam int BIT_INTERLEAVE = 1;
   localparam int BIT_CLIP_EN = 6;
   localparam int CLIP_W = 6;

   localparam logic [7:0] RST_COLOR_SEL = 8'h01;
   localparam logic [7:0] RST_EXP_CTRL = 8'h00;
   localparam logic [23:0] RST_EXP_TIME = 24'h000800;
   localparam logic [23:0] RST_KNEE = 24'h000001;
   localparam logic [1:0] RST_SLOPES = 2'h1;
   localparam logic [6:0] RST_CLIP = 7'h60;
   // Overhead length reset value is arbitrary
   localparam logic [7:0] RST_FOT = 8'h0a;

   // Timing unit is this many master clock periods
   localparam int TICK_PERIOD = 129;
   localparam int TICK_W = 8;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_PERIOD - 1);
   localparam logic [6:0] OVH_NUM = 7'h2b;
   localparam logic [14:0] OVH_DEN = 15'h0064;

   localparam int N_TIMERS = 5;
   localparam int T_EVEN = 0;
   localparam int T_ODD = 1;
   localparam int T_KNEE1 = 2;
   localparam int T_KNEE2 = 3;
   localparam int T_OVH = 4;

   typedef enum logic [1:0] {ST_IDLE, ST_INT_EXP, ST_EXT_EXP, ST_EXT_OVH} hes_state_t;
endpackage : hes_pkg

// [verilog/hes_tick_gen.sv]
// Divider giving one tick per exposure time unit
`timescale 1ns/1ps
`default_nettype none
module hes_tick_gen (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic restart,
   output logic tick
);
   logic [hes_pkg::TICK_W-1:0] cnt_q;
   logic [hes_pkg::TICK_W-1:0] cnt_d;
   wire atLast = (cnt_q == hes_pkg::TICK_LAST);

   assign cnt_d = (restart || atLast) ? '0 : cnt_q + 1'b1;
   assign tick = atLast && !restart;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule : hes_tick_gen
`default_nettype wire

// [verilog/hes_unit_timer.sv]
// Counts time units from a start pulse up to a target
`timescale 1ns/1ps
`default_nettype none
module hes_unit_timer (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire logic tick,
   input wire logic [hes_pkg::TGT_W-1:0] target,
   output logic busy,
   output logic donePulse
);
   logic [hes_pkg::TGT_W-1:0] cnt_q;
   logic busy_q;
   logic done_q;
   wire [hes_pkg::TGT_W-1:0] cntInc = cnt_q + 1'b1;
   wire reach = busy_q && tick && (cntInc >= target);
   wire zeroStart = start && (target == '0);

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= reach || zeroStart;
         if (start)
         begin
            cnt_q <= '0;
            busy_q <= !zeroStart;
         end
         else if (busy_q && tick)
         begin
            cnt_q <= cntInc;
            busy_q <= !reach;
         end
      end
   end

   assign busy = busy_q;
   assign donePulse = done_q;
endmodule : hes_unit_timer
`default_nettype wire

// [bench/hes_ctrl_model.sv]
// Camera controller model driving the trigger and frame request pins
`timescale 1ns/1ps
`default_nettype none
module hes_ctrl_model #(
   parameter int HOLD = 4
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic fireFirst,
   input wire logic fireSecond,
   input wire logic fireFrame,
   output logic firstExposureTrigger,
   output logic secondExposureTrigger,
   output logic frameReq
);
   int holdA;
   int holdB;
   bit frameQ;
   // Trigger pins stay high HOLD cycles, so only their rising edge can start anything; frame request is a one-cycle pulse
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         holdA <= 0;
         holdB <= 0;
         frameQ <= 1'b0;
      end
      else
      begin
         holdA <= fireFirst ? HOLD : (holdA > 0 ? holdA - 1 : 0);
         holdB <= fireSecond ? HOLD : (holdB > 0 ? holdB - 1 : 0);
         frameQ <= fireFrame;
      end
   end
   assign firstExposureTrigger = holdA > 0;
   assign secondExposureTrigger = holdB > 0;
   assign frameReq = frameQ;
endmodule : hes_ctrl_model
`default_nettype wire

// [bench/hes_exposure_seq_sva.sv]
// Port assertions for the exposure sequencer
`timescale 1ns/1ps
`default_nettype none
module hes_exposure_seq_sva (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [hes_pkg::ADDR_W-1:0] regAddr,
   input wire logic [hes_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic frameReq,
   input wire logic firstExposureTrigger,
   input wire logic secondExposureTrigger,
   input wire logic evenExposing,
   input wire logic oddExposing,
   input wire logic exposureDone,
   input wire logic [1:0] clipStage,
   input wire logic clipEnable
);
   logic [1:0] modeQ;
   wire logic idle;
   assign idle = !evenExposing && !oddExposing && !exposureDone;
   // Shadow of the mode bits, so the checker knows which start is legal
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         modeQ <= 2'h0;
      else if (regWrEn && regAddr == hes_pkg::ADDR_EXP_CTRL)
         modeQ <= regWrData[1:0];
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   sequence s_launch;
      !evenExposing ##1 evenExposing;
   endsequence
   sequence s_quiet;
      !evenExposing [*2];
   endsequence
   property p_int_start;
      frameReq && idle && !modeQ[0] |=> s_launch;
   endproperty
   a_int_start: assert property (p_int_start) else $error("internal start late");
   property p_ext_start;
      $rose(firstExposureTrigger) && idle && modeQ[0] |=> s_launch;
   endproperty
   a_ext_start: assert property (p_ext_start) else $error("external start late");
   property p_odd_start;
      $rose(secondExposureTrigger) && evenExposing && !oddExposing && modeQ == 2'h3 && !frameReq
         |=> !oddExposing ##1 oddExposing;
   endproperty
   a_odd_start: assert property (p_odd_start) else $error("odd start late");
   property p_shared;
      !modeQ[1] |-> evenExposing == oddExposing;
   endproperty
   a_shared: assert property (p_shared) else $error("row sets split");
   property p_ext_refuse;
      modeQ[0] && frameReq && idle && !firstExposureTrigger && !$past(firstExposureTrigger)
         |=> s_quiet;
   endproperty
   a_ext_refuse: assert property (p_ext_refuse) else $error("frame without trigger");
   property p_int_refuse;
      !modeQ[0] && $rose(firstExposureTrigger) && idle && !frameReq && !$past(frameReq)
         |=> s_quiet;
   endproperty
   a_int_refuse: assert property (p_int_refuse) else $error("trigger used internally");
   property p_done;
      exposureDone |-> !evenExposing && !oddExposing && ($past(evenExposing) || $past(oddExposing));
   endproperty
   a_done: assert property (p_done) else $error("done out of place");
   property p_done_once;
      exposureDone |=> !exposureDone;
   endproperty
   a_done_once: assert property (p_done_once) else $error("done too long");
   property p_stage_max;
      clipStage != 2'h3;
   endproperty
   a_stage_max: assert property (p_stage_max) else $error("third clip change");
   property p_stage_step;
      clipStage != $past(clipStage) |-> clipStage == $past(clipStage) + 2'h1 || clipStage == 2'h0;
   endproperty
   a_stage_step: assert property (p_stage_step) else $error("stage skipped");
   property p_clip_off;
      clipStage == 2'h0 |-> !clipEnable;
   endproperty
   a_clip_off: assert property (p_clip_off) else $error("clip before knee");
endmodule : hes_exposure_seq_sva
bind hes_exposure_seq hes_exposure_seq_sva u_sva (
   .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
   .regWrEn(regWrEn), .frameReq(frameReq), .firstExposureTrigger(firstExposureTrigger),
   .secondExposureTrigger(secondExposureTrigger), .evenExposing(evenExposing),
   .oddExposing(oddExposing), .exposureDone(exposureDone), .clipStage(clipStage),
   .clipEnable(clipEnable));
`default_nettype wire

// [bench/hes_exposure_seq_test.sv]
// Self-checking bench for the exposure sequencer
`timescale 1ns/1ps
`default_nettype none
module hes_exposure_seq_test;
   localparam int UNIT = 129;
   localparam int OVH = 5 * 43 / 100;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [6:0] regAddr = 7'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrEn = 1'b0;
   logic [10:0] rowIndex = 11'h000;
   logic fireFirst = 1'b0;
   logic fireSecond = 1'b0;
   logic fireFrame = 1'b0;
   wire logic frameReq;
   wire logic trigA;
   wire logic trigB;
   wire logic evenExposing;
   wire logic oddExposing;
   wire logic rowExposing;
   wire logic exposureDone;
   wire logic clipEnable;
   wire logic [1:0] clipStage;
   wire logic [5:0] clipLevel;
   wire logic [7:0] regRdData;
   int num_errors = 0;
   int checks_done = 0;
   int evenN;
   int oddN;
   int i;
   int s;
   logic [1:0] topStage;
   logic [6:0] clip1;
   logic [6:0] clip2;
   // Address, reset value, byte written, value read back
   logic [30:0] rows [16] = '{{7'h27, 8'h01, 8'hff, 8'h01}, {7'h29, 8'h00, 8'hfe, 8'h02},
      {7'h2a, 8'h00, 8'ha5, 8'ha5}, {7'h2b, 8'h08, 8'h5a, 8'h5a}, {7'h2c, 8'h00, 8'hc3, 8'hc3},
      {7'h30, 8'h01, 8'h11, 8'h11}, {7'h32, 8'h00, 8'h22, 8'h22}, {7'h33, 8'h01, 8'h33, 8'h33},
      {7'h36, 8'h01, 8'hff, 8'h03}, {7'h37, 8'h00, 8'hff, 8'h00}, {7'h38, 8'h00, 8'h44, 8'h44},
      {7'h39, 8'h08, 8'h55, 8'h55}, {7'h49, 8'h0a, 8'hff, 8'hff}, {7'h59, 8'h60, 8'hff, 8'h7f},
      {7'h5a, 8'h60, 8'h80, 8'h00}, {7'h7f, 8'h00, 8'hff, 8'h00}};
   hes_exposure_seq u_dut (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .frameReq(frameReq),
      .firstExposureTrigger(trigA), .secondExposureTrigger(trigB), .rowIndex(rowIndex),
      .evenExposing(evenExposing), .oddExposing(oddExposing), .rowExposing(rowExposing),
      .exposureDone(exposureDone), .clipStage(clipStage), .clipEnable(clipEnable),
      .clipLevel(clipLevel));
   hes_ctrl_model u_ctrl (.clk_sys(clk_sys), .resetn(resetn), .fireFirst(fireFirst),
      .fireSecond(fireSecond), .fireFrame(fireFrame), .firstExposureTrigger(trigA),
      .secondExposureTrigger(trigB), .frameReq(frameReq));
   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step
   task automatic checkEq(input string what, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", what, e, g);
         num_errors++;
      end
   endtask : checkEq
   // Timer start and tick phase each cost up to a cycle, hence the slack
   task automatic checkNear(input string what, input int e, input int g);
      checks_done++;
      if (g < e - 3 || g > e + 3)
      begin
         $display("[FAIL] %s expected %0d seen %0d", what, e, g);
         num_errors++;
      end
   endtask : checkNear
   task automatic wrReg(input logic [6:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      step();
      regWrEn = 1'b0;
      step();
   endtask : wrReg
   task automatic wr24(input logic [6:0] a, input logic [23:0] v);
      wrReg(a, v[7:0]);
      wrReg(a + 7'h01, v[15:8]);
      wrReg(a + 7'h02, v[23:16]);
   endtask : wr24
   task automatic fire(input int k);
      fireFirst = (k == 1);
      fireSecond = (k == 2);
      fireFrame = (k == 3);
      step();
      fireFirst = 1'b0;
      fireSecond = 1'b0;
      fireFrame = 1'b0;
   endtask : fire
   task automatic tally();
      evenN += (evenExposing === 1'b1);
      oddN += (oddExposing === 1'b1);
      if (clipStage === 2'h1)
         clip1 = {clipEnable, clipLevel};
      if (clipStage === 2'h2)
         clip2 = {clipEnable, clipLevel};
      if (clipStage > topStage)
         topStage = clipStage;
   endtask : tally
   task automatic runFrame(input int gap, input int secondAt);
      int n;
      evenN = 0;
      oddN = 0;
      topStage = 2'h0;
      for (n = 0; n < gap; n++)
      begin
         if (n == secondAt)
            fireSecond = 1'b1;
         else if (n == secondAt + 1 && secondAt >= 0)
            fireSecond = 1'b0;
         step();
         tally();
      end
      fire(3);
      tally();
      for (n = 0; n < 6000 && exposureDone !== 1'b1; n++)
      begin
         step();
         tally();
      end
      if (exposureDone !== 1'b1)
      begin
         $display("[FAIL] frame end expected 1 seen %b", exposureDone);
         num_errors++;
         print_verdict();
      end
   endtask : runFrame
   task automatic doReset();
      resetn = 1'b0;
      repeat (6) step();
      resetn = 1'b1;
   endtask : doReset
   initial
   begin
      doReset();
      checkEq("idle outputs", 8'h00, {3'h0, evenExposing, oddExposing, rowExposing,
         exposureDone, clipEnable});
      for (i = 0; i < 16; i++)
      begin
         regAddr = rows[i][30:24];
         step();
         checkEq("reset value", rows[i][23:16], regRdData);
         wrReg(rows[i][30:24], rows[i][15:8]);
         checkEq("readback", rows[i][7:0], regRdData);
      end
      doReset();
      regAddr = hes_pkg::ADDR_EXP_PRI + 7'h01;
      step();
      checkEq("value after reset", 8'h08, regRdData);
      $display("test registers done");
      wrReg(hes_pkg::ADDR_FOT, 8'h05);
      wr24(hes_pkg::ADDR_EXP_PRI, 24'h000002);
      runFrame(0, -1);
      checkNear("even length", (2 + OVH) * UNIT, evenN);
      checkNear("odd shares", (2 + OVH) * UNIT, oddN);
      wrReg(hes_pkg::ADDR_EXP_CTRL, 8'h02);
      wr24(hes_pkg::ADDR_EXP_SEC, 24'h000001);
      runFrame(0, -1);
      checkNear("even interleaved", (2 + OVH) * UNIT, evenN);
      checkNear("odd interleaved", (1 + OVH) * UNIT, oddN);
      $display("test internal done");
      wrReg(hes_pkg::ADDR_EXP_CTRL, 8'h00);
      wr24(hes_pkg::ADDR_KNEE1, 24'h000000);
      wr24(hes_pkg::ADDR_KNEE2, 24'h000001);
      wrReg(hes_pkg::ADDR_CLIP2, 8'h45);
      wrReg(hes_pkg::ADDR_CLIP3, 8'h0a);
      for (s = 0; s < 4; s++)
      begin
         wrReg(hes_pkg::ADDR_SLOPES, 8'(s));
         runFrame(0, -1);
         checkEq("top stage", (s < 2) ? 8'h00 : 8'(s - 1), {6'h00, topStage});
         if (s > 1)
            checkEq("first clip", 8'h45, {1'b0, clip1});
         if (s > 2)
            checkEq("second clip", 8'h0a, {1'b0, clip2});
      end
      $display("test slopes done");
      fire(1);
      repeat (10) step();
      checkEq("trigger ignored", 8'h00, {7'h00, evenExposing});
      wrReg(hes_pkg::ADDR_EXP_CTRL, 8'h01);
      fire(3);
      repeat (10) step();
      checkEq("early frame ignored", 8'h00, {7'h00, evenExposing});
      fire(1);
      runFrame(20, -1);
      checkNear("external even", 21 + OVH * UNIT, evenN);
      checkNear("external odd", 21 + OVH * UNIT, oddN);
      wrReg(hes_pkg::ADDR_EXP_CTRL, 8'h03);
      fire(1);
      runFrame(30, 10);
      checkNear("external even pin", 31 + OVH * UNIT, evenN);
      checkNear("external odd pin", 20 + OVH * UNIT, oddN);
      $display("test external done");
      wrReg(hes_pkg::ADDR_COLOR_SEL, 8'h00);
      fire(1);
      repeat (4) step();
      for (s = 0; s < 3; s++)
      begin
         if (s == 2)
            wrReg(hes_pkg::ADDR_COLOR_SEL, 8'h01);
         rowIndex = (s == 0) ? 11'h001 : 11'h002;
         repeat (2) step();
         checkEq("row set", (s == 1) ? 8'h00 : 8'h01, {7'h00, rowExposing});
      end
      runFrame(4, 1);
      $display("test row sets done");
      print_verdict();
   end
endmodule : hes_exposure_seq_test
`default_nettype wire
